// File: src/oob_defines.vh
// Purpose: Shared constants for the out-of-band symbol and frame link
// Assumes: 20 MHz system clock
// Notes:   Times in ns, cycle counts derived from the clock period
`ifndef OOB_DEFINES_VH
`define OOB_DEFINES_VH
`define OOB_CLK_PERIOD_NS      50
`define OOB_TX_DELAY_MAX_NS    180
`define OOB_TX_DELAY_CYC       ((`OOB_TX_DELAY_MAX_NS / `OOB_CLK_PERIOD_NS) < 1 ? 1 : \
                                (`OOB_TX_DELAY_MAX_NS / `OOB_CLK_PERIOD_NS))
`define OOB_LEN_W              16
`define OOB_BYTE_W             8
`define OOB_MODE_LEGACY        1'b0
`define OOB_MODE_GATEWAY       1'b1
`define OOB_MAX_FRAME_DEF      16'h05ee
`endif

// File: src/oob_sync.v
// Purpose: Two-flop synchroniser with edge detection on the second stage output
// Assumes: Input is asynchronous to mclk
// Notes:   The first flop feeds only the second flop
`timescale 1ns/1ps
module oob_sync (
    input  wire mclk,
    input  wire rst,
    input  wire din,
    output reg  dout,
    output wire rise
);
    reg meta;
    reg last;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            dout <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
            last <= dout;
        end
    end
    assign rise = dout & ~last;
endmodule

// File: src/oob_buf2.v
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock
// Notes:   Full and empty are exact; ready drops only when both entries hold data
`timescale 1ns/1ps
module oob_buf2 #(
    parameter W = 8
) (
    input  wire         mclk,
    input  wire         rst,
    input  wire [W-1:0] in_data,
    input  wire         in_valid,
    output wire         in_ready,
    output wire [W-1:0] out_data,
    output wire         out_valid,
    input  wire         out_ready
);
    reg [W-1:0] mem [0:1];
    reg         wp;
    reg         rp;
    reg [1:0]   cnt;
    wire        wr = in_valid & in_ready;
    wire        rd = out_valid & out_ready;
    assign in_ready  = (cnt != 2'd2);
    assign out_valid = (cnt != 2'd0);
    assign out_data  = mem[rp];
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            wp     <= 1'b0;
            rp     <= 1'b0;
            cnt    <= 2'd0;
            mem[0] <= {W{1'b0}};
            mem[1] <= {W{1'b0}};
        end else begin
            if (wr) begin
                mem[wp] <= in_data;
                wp      <= ~wp;
            end
            if (rd)
                rp <= ~rp;
            if (wr & ~rd)
                cnt <= cnt + 2'd1;
            else if (rd & ~wr)
                cnt <= cnt - 2'd1;
        end
    end
endmodule

// File: src/oob_link.v
// Purpose: Device end of the out-of-band link: serial downstream, I/Q upstream, gateway frames
// Assumes: Link clocks come from the host and are sampled by mclk (max 3.088 MHz)
// Notes:   Link and MAC layers above this block are outside; it supplies bytes and symbols
`timescale 1ns/1ps
`include "oob_defines.vh"
module oob_link #(
    parameter MAX_FRAME = `OOB_MAX_FRAME_DEF
) (
    input  wire        mclk,
    input  wire        rst,
    input  wire        gateway_mode,
    input  wire        rx_serial_data,
    input  wire        rx_gapped_clock,
    output wire [7:0]  rx_byte,
    output wire        rx_byte_valid,
    input  wire        rx_byte_ready,
    output reg         rx_frame_start,
    output reg         rx_frame_drop,
    output wire        rx_overrun,
    input  wire        tx_symbol_clock,
    input  wire [1:0]  tx_sym,
    input  wire        tx_sym_valid,
    output wire        tx_sym_ready,
    input  wire        tx_burst_end,
    output reg         tx_inphase_bit,
    output reg         tx_quadrature_bit,
    output reg         tx_enable_out,
    output wire        ext_channel_sel
);
    // Downstream clock and data pass two flops each; data gets no extra delay and is sampled on the synchronised clock rise
    wire       rxc_s;
    wire       rxc_rise;
    wire       rxd_s;
    wire       txc_s;
    wire       txc_rise;
    oob_sync u_rxc (
        .mclk (mclk),
        .rst  (rst),
        .din  (rx_gapped_clock),
        .dout (rxc_s),
        .rise (rxc_rise)
    );
    oob_sync u_rxd (
        .mclk (mclk),
        .rst  (rst),
        .din  (rx_serial_data),
        .dout (rxd_s),
        .rise ()
    );
    oob_sync u_txc (
        .mclk (mclk),
        .rst  (rst),
        .din  (tx_symbol_clock),
        .dout (txc_s),
        .rise (txc_rise)
    );

    // Bit assembly: only clock edges shift, so gaps cost nothing
    reg  [7:0] shreg;
    reg  [2:0] bitcnt;
    reg        byte_stb;
    reg  [7:0] byte_val;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            shreg    <= 8'h00;
            bitcnt   <= 3'd0;
            byte_stb <= 1'b0;
            byte_val <= 8'h00;
        end else begin
            byte_stb <= 1'b0;
            if (rxc_rise) begin
                shreg  <= {shreg[6:0], rxd_s};
                bitcnt <= bitcnt + 3'd1;
                if (bitcnt == 3'd7) begin
                    byte_stb <= 1'b1;
                    byte_val <= {shreg[6:0], rxd_s};
                end
            end
        end
    end

    // Gateway framing: length high, length low, payload; no CRC anywhere
    localparam [3:0] ST_LEN_HI = 4'b0001;
    localparam [3:0] ST_LEN_LO = 4'b0010;
    localparam [3:0] ST_DATA   = 4'b0100;
    localparam [3:0] ST_SKIP   = 4'b1000;
    reg  [3:0]  state;
    reg  [3:0]  next_state;
    reg  [15:0] len;
    reg  [15:0] remain;
    reg         ovr;
    wire        buf_in_ready;
    reg         push;
    always @* begin
        next_state = state;
        push       = 1'b0;
        case (state)
            ST_LEN_HI: begin
                if (byte_stb)
                    next_state = ST_LEN_LO;
            end
            ST_LEN_LO: begin
                if (byte_stb) begin
                    if ({len[15:8], byte_val} == 16'h0000 ||
                        {len[15:8], byte_val} > MAX_FRAME)
                        next_state = ST_LEN_HI;
                    else
                        next_state = ST_DATA;
                end
            end
            ST_DATA: begin
                if (byte_stb) begin
                    push = buf_in_ready;
                    if (!buf_in_ready)
                        next_state = (remain == 16'd1) ? ST_LEN_HI : ST_SKIP;
                    else if (remain == 16'd1)
                        next_state = ST_LEN_HI;
                end
            end
            ST_SKIP: begin
                if (byte_stb && remain == 16'd1)
                    next_state = ST_LEN_HI;
            end
            default: next_state = ST_LEN_HI;
        endcase
        if (!gateway_mode) begin
            next_state = ST_LEN_HI;
            push       = byte_stb & buf_in_ready;
        end
    end

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state          <= ST_LEN_HI;
            len            <= 16'h0000;
            remain         <= 16'h0000;
            rx_frame_start <= 1'b0;
            rx_frame_drop  <= 1'b0;
            ovr            <= 1'b0;
        end else begin
            state          <= next_state;
            rx_frame_start <= 1'b0;
            rx_frame_drop  <= 1'b0;
            ovr            <= byte_stb & ~buf_in_ready & ~gateway_mode;
            if (gateway_mode && byte_stb) begin
                case (state)
                    ST_LEN_HI: len[15:8] <= byte_val;
                    ST_LEN_LO: begin
                        len[7:0] <= byte_val;
                        remain   <= {len[15:8], byte_val};
                        if (next_state == ST_DATA)
                            rx_frame_start <= 1'b1;
                        else
                            rx_frame_drop <= 1'b1;
                    end
                    ST_DATA: begin
                        remain <= remain - 16'd1;
                        if (!buf_in_ready)
                            rx_frame_drop <= 1'b1;
                    end
                    ST_SKIP: remain <= remain - 16'd1;
                    default: remain <= remain;
                endcase
            end
        end
    end
    assign rx_overrun = ovr;

    oob_buf2 #(
        .W (`OOB_BYTE_W)
    ) u_buf (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   (byte_val),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .out_data  (rx_byte),
        .out_valid (rx_byte_valid),
        .out_ready (rx_byte_ready)
    );

    // Upstream: one symbol per symbol-clock rising edge, differentially encoded
    reg [1:0] phase;
    reg       sym_take;
    wire [1:0] next_phase = phase + tx_sym;
    assign tx_sym_ready = txc_rise & ~gateway_mode;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase             <= 2'b00;
            tx_inphase_bit    <= 1'b0;
            tx_quadrature_bit <= 1'b0;
            tx_enable_out     <= 1'b0;
            sym_take          <= 1'b0;
        end else begin
            sym_take <= 1'b0;
            if (gateway_mode) begin
                tx_enable_out <= 1'b0;
                phase         <= 2'b00;
            end else if (txc_rise) begin
                if (tx_sym_valid) begin
                    phase             <= next_phase;
                    tx_inphase_bit    <= next_phase[1] ^ next_phase[0];
                    tx_quadrature_bit <= next_phase[1];
                    tx_enable_out     <= 1'b1;
                    sym_take          <= 1'b1;
                end else begin
                    tx_enable_out <= 1'b0;
                    if (tx_burst_end)
                        phase <= 2'b00;
                end
            end
        end
    end
    // Gateway upstream uses the extended channel elsewhere
    assign ext_channel_sel = gateway_mode;
endmodule

// File: verif/oob_host_model.sv
// Purpose: Host end of the link pins
// Assumes: 400 ns link period
// Notes:   Clocks stand still outside bursts
`timescale 1ns/1ps
module oob_host_model (
    output reg rx_serial_data,
    output reg rx_gapped_clock,
    output reg tx_symbol_clock
);
    initial {rx_serial_data, rx_gapped_clock, tx_symbol_clock} = 3'h0;
    task automatic send_byte(input [7:0] d);
        integer k;
        for (k = 7; k >= 0; k = k - 1) begin
            rx_serial_data = d[k];
            #200 rx_gapped_clock = 1'b1;
            #200 rx_gapped_clock = 1'b0;
        end
        rx_serial_data = ~d[0];
        #1000;
    endtask
    task automatic sym_pulse;
        #200 tx_symbol_clock = 1'b1;
        #200 tx_symbol_clock = 1'b0;
    endtask
endmodule

// File: verif/oob_link_chk.sv
// Purpose: Upstream port checks
// Assumes: tx_burst_end low
// Notes:   phase mirrors the encoder
`timescale 1ns/1ps
module oob_link_chk (
    input wire       mclk,
    input wire       rst,
    input wire       gateway_mode,
    input wire [1:0] tx_sym,
    input wire       tx_sym_valid,
    input wire       tx_sym_ready,
    input wire       tx_inphase_bit,
    input wire       tx_quadrature_bit,
    input wire       tx_enable_out,
    input wire       ext_channel_sel
);
    reg  [1:0] phase;
    wire       take = tx_sym_ready && tx_sym_valid;
    always @(posedge mclk or posedge rst) begin
        if (rst) phase <= 2'h0;
        else if (take) phase <= phase + tx_sym;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_on; take |=> tx_enable_out; endproperty
    a_on: assert property (p_on) else $error("enable low");
    property p_off; tx_sym_ready && !tx_sym_valid |=> !tx_enable_out; endproperty
    a_off: assert property (p_off) else $error("enable high");
    property p_q; take |=> tx_quadrature_bit == phase[1]; endproperty
    a_q: assert property (p_q) else $error("q bit");
    property p_i; take |=> tx_inphase_bit == (phase[1] ^ phase[0]); endproperty
    a_i: assert property (p_i) else $error("i bit");
    property p_hold; !tx_sym_ready && !gateway_mode |=>
        $stable({tx_inphase_bit, tx_quadrature_bit, tx_enable_out}); endproperty
    a_hold: assert property (p_hold) else $error("tx moved");
    property p_one; tx_sym_ready |=> !tx_sym_ready; endproperty
    a_one: assert property (p_one) else $error("ready long");
    property p_sel; ext_channel_sel == gateway_mode; endproperty
    a_sel: assert property (p_sel) else $error("channel");
    property p_gw; gateway_mode |-> !tx_sym_ready; endproperty
    a_gw: assert property (p_gw) else $error("legacy tx");
endmodule
bind oob_link oob_link_chk i_oob_link_chk (.*);

// File: verif/test_oob_link.sv
// Purpose: Self-checking bench for oob_link
// Assumes: Host model drives the link pins
// Notes:   I/Q coding is judged by the checker
`timescale 1ns/1ps
module test_oob_link;
    reg        mclk = 1'b0, rst = 1'b1, gateway_mode = 1'b0, rx_byte_ready = 1'b0;
    reg        tx_sym_valid = 1'b0, stall = 1'b1;
    reg  [1:0] tx_sym = 2'h0;
    wire       rx_serial_data, rx_gapped_clock, tx_symbol_clock, rx_byte_valid, rx_overrun;
    wire       rx_frame_start, rx_frame_drop, tx_sym_ready, tx_inphase_bit, tx_enable_out;
    wire       tx_quadrature_bit, ext_channel_sel;
    wire       tx_burst_end = 1'b0;
    wire [7:0] rx_byte;
    integer    mismatches = 0, check_count = 0, seed = 96, i, w, n_st = 0, n_dr = 0, n_ov = 0;
    reg  [7:0] exp_b[$];
    oob_link i_oob_link (.*);
    oob_host_model i_oob_host_model (.*);
    initial forever #25 mclk = ~mclk;
    task check(input [7:0] seen, want, input [63:0] what);
        check_count = check_count + 1;
        if (seen !== want) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0s expected %h seen %h", what, want, seen);
        end
    endtask
    task final_report;
        if (mismatches == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task hang;
        mismatches = mismatches + 1;
        final_report;
    endtask
    always @(negedge mclk) begin
        rx_byte_ready <= !stall && 1'($random(seed));
        #5;
        if ((rx_byte_valid & rx_byte_ready) === 1'b1)
            check(rx_byte, exp_b.pop_front(), "byte");
        n_st = n_st + (rx_frame_start === 1'b1);
        n_dr = n_dr + (rx_frame_drop === 1'b1);
        n_ov = n_ov + (rx_overrun === 1'b1);
    end
    task send_sym(input v, input [1:0] s);
        tx_sym = s;
        tx_sym_valid = v;
        fork
            i_oob_host_model.sym_pulse;
        join_none
        for (w = 0; w < 40 && tx_sym_ready !== 1'b1; w = w + 1) @(negedge mclk);
        if (w == 40) hang;
        @(negedge mclk);
        tx_sym_valid = 1'b0;
        check(tx_enable_out, v, "enable");
        repeat (4) @(negedge mclk);
    endtask
    task drain;
        for (w = 0; w < 400 && exp_b.size() != 0; w = w + 1) @(negedge mclk);
        if (w == 400) hang;
    endtask
    task send_frame(input [15:0] len, input integer k);
        i_oob_host_model.send_byte(len[15:8]);
        i_oob_host_model.send_byte(len[7:0]);
        repeat (k) begin
            exp_b.push_back(8'($random(seed)));
            i_oob_host_model.send_byte(exp_b[$]);
        end
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        for (i = 0; i < 8; i = i + 1) send_sym(1'b1, 2'($random(seed)));
        send_sym(1'b0, 2'h0);
        // Third byte meets a full buffer and is lost
        for (i = 0; i < 3; i = i + 1) begin
            if (i < 2) exp_b.push_back(8'($random(seed)));
            i_oob_host_model.send_byte(i < 2 ? exp_b[$] : 8'h5a);
        end
        stall = 1'b0;
        drain;
        check(8'(n_ov), 8'h01, "overrun");
        gateway_mode = 1'b1;
        send_frame(16'h0003, 3);
        send_frame(16'h0000, 0);
        send_frame(16'h05ef, 0);
        send_frame(16'h0001, 1);
        drain;
        check(8'(n_st), 8'h02, "start");
        check(8'(n_dr), 8'h02, "drop");
        final_report;
    end
endmodule
